/* File: src/cycle_timing_pkg.sv */
// Constants and types shared by the instruction cycle sequencer
package cycle_timing_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned INT_CYCLE_NS    = 20;                 // One core clock period
  localparam int unsigned INT_CYCLE_CLKS  = (INT_CYCLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Fetch counts
  localparam logic [1:0]  FETCH_NORMAL    = 2'h1;
  localparam logic [1:0]  FETCH_BRANCH    = 2'h3;
  // Internal cycle counts
  localparam logic [4:0]  INT_NONE        = 5'h00;
  localparam logic [4:0]  INT_ONE         = 5'h01;
  localparam logic [4:0]  INT_CP15        = 5'h02;
  localparam logic [4:0]  INT_MUL_MAX     = 5'h10;
  // Multiplier thresholds
  localparam int unsigned MUL_CAP_BIT     = 29;
  // Accepted coprocessor
  localparam logic [3:0]  CP_SYSCTRL      = 4'hF;
  localparam logic [3:0]  CP_REG_LIMIT    = 4'h7;
  // Instruction classes presented by decode
  typedef enum logic [3:0] {
    CLS_DATA_PROC                = 4'h0,
    CLS_PSR_MOVE                 = 4'h1,
    CLS_LOAD_SINGLE_WORD         = 4'h2,
    CLS_STORE_SINGLE_WORD        = 4'h3,
    CLS_LOAD_MULTIPLE_WORDS      = 4'h4,
    CLS_STORE_MULTIPLE_WORDS     = 4'h5,
    CLS_ATOMIC_SWAP              = 4'h6,
    CLS_BRANCH                   = 4'h7,
    CLS_SOFTWARE_INTERRUPT_OP    = 4'h8,
    CLS_MULTIPLY_OP              = 4'h9,
    CLS_COPROCESSOR_DATA_OP      = 4'hA,
    CLS_COPROCESSOR_LOAD         = 4'hB,
    CLS_COPROCESSOR_STORE        = 4'hC,
    CLS_MOVE_TO_COPROCESSOR      = 4'hD,
    CLS_MOVE_FROM_COPROCESSOR    = 4'hE
  } instr_class_e;
  // Execute phases, gray coded along idle, read, write, internal, fetch
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0,
    PH_READ  = 3'h1,
    PH_WRITE = 3'h3,
    PH_INT   = 3'h2,
    PH_FETCH = 3'h6
  } phase_e;
endpackage

/* File: src/instruction_cycle_timing.sv */
// Execute-stage cycle sequencer for a three stage fetch/decode/execute pipeline
`timescale 1ns/100ps

// Functional notes
// RULE1: Three instructions overlap: execute, decode, fetch
// RULE2: Failed condition costs one fetch only
// RULE3: Data op: 1 fetch; shift +1I; PC 3F
// RULE4: Load word: 1F 1R 1I; PC 3F
// RULE5: Store word: 1 fetch, 1 write
// RULE6: Load multiple: 1F nR 1I; PC 3F
// RULE7: Store multiple: 1 fetch, n writes
// RULE8: Swap: fetch, read, write, internal in order; the sequencer does read, write, internal, then the fetch last
// RULE9: Multiply: 1 fetch plus m internal cycles
// RULE10: Multiplier 0 or 1 costs 1S+1I
// RULE11: Multiplier at/above 2^29 costs 1S+16I
// RULE12: Coprocessor data/load/store take undefined trap
// RULE13: Only CP15 registers 0-7 transfers accepted
// RULE14: CP15 transfer: 1 fetch, 2 internal cycles
// RULE15: Internal cycle lasts one core clock
// RULE16: Fetch/read one cycle on hit, else stall
// RULE17: Buffered write stalls until buffer space
// RULE18: Buffer disabled: write waits full access
// RULE19: Coprocessor cycle lasts one coprocessor-clock period
// RULE20: Hold decode/fetch while execute waits memory
module instruction_cycle_timing
  import cycle_timing_pkg::*;
#(
  parameter int unsigned WORD_CNT_W = 5
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  instr_valid_i,
  input  wire logic [3:0]            instr_class_i,
  input  wire logic                  cond_pass_i,
  input  wire logic                  reg_shift_i,
  input  wire logic                  pc_written_i,
  input  wire logic [WORD_CNT_W-1:0] word_count_i,
  input  wire logic [31:0]           multiplier_operand_register_i,
  input  wire logic [3:0]            cp_num_i,
  input  wire logic [3:0]            cp_reg_i,
  input  wire logic                  coprocessor_clock_en_i,
  input  wire logic                  cache_hit_i,
  input  wire logic                  mem_done_i,
  input  wire logic                  wbuf_enable_i,
  input  wire logic                  wbuf_space_i,
  output logic                       instr_ready_o,
  output logic                       advance_o,
  output logic                       fetch_cycle_o,
  output logic                       read_cycle_o,
  output logic                       write_cycle_o,
  output logic                       internal_cycle_o,
  output logic                       mem_request_o,
  output logic                       undef_trap_o,
  output logic [5:0]                 cycle_total_o
);

  typedef struct packed {
    phase_e                 phase;
    logic [WORD_CNT_W:0]    reads;
    logic [WORD_CNT_W:0]    writes;
    logic [4:0]             ints;
    logic [1:0]             fetches;
    logic                   swap_write;
    logic                   cp_slow;
    logic                   trap;
    logic [5:0]             total;
  } state_s;

  state_s st;
  state_s next_st;

  // Early-terminating multiply: m from multiplier magnitude
  function automatic logic [4:0] mul_cycles(input logic [31:0] v);
    logic [4:0] m;
    m = INT_ONE; // RULE10
    for (int k = 2; k <= 16; k++) begin
      if (v >= (32'h1 << (2 * k - 3))) begin
        m = 5'(k); // RULE9
      end
    end
    if (v >= (32'h1 << MUL_CAP_BIT)) begin
      m = INT_MUL_MAX; // RULE11
    end
    return m;
  endfunction

  instr_class_e cls;
  logic         cp_ok;
  logic         busy;
  logic         mem_phase;
  logic         mem_wait;
  logic         step;
  logic [WORD_CNT_W:0] n_words;

  assign cls       = instr_class_e'(instr_class_i);
  assign cp_ok     = (cp_num_i == CP_SYSCTRL) && (cp_reg_i <= CP_REG_LIMIT); // RULE13
  assign busy      = (st.phase != PH_IDLE);
  assign n_words   = {1'b0, word_count_i};
  assign mem_phase = (st.phase == PH_READ) || (st.phase == PH_WRITE) || (st.phase == PH_FETCH);

  // Stall decision per access kind
  always_comb begin
    mem_wait = 1'b0;
    case (st.phase)
      PH_FETCH: mem_wait = !cache_hit_i && !mem_done_i; // RULE16
      PH_READ:  mem_wait = !cache_hit_i && !mem_done_i; // RULE16
      PH_WRITE: mem_wait = wbuf_enable_i ? !wbuf_space_i : !mem_done_i; // RULE17 RULE18
      PH_INT:   mem_wait = st.cp_slow && !coprocessor_clock_en_i; // RULE19
      default:  mem_wait = 1'b0;
    endcase
  end
  assign step = busy && !mem_wait; // RULE15

  // Sequencer: load counts on accept, then walk R, W, I, then every fetch
  always_comb begin
    next_st = st;
    if (!busy && instr_valid_i) begin
      next_st.reads      = '0;
      next_st.writes     = '0;
      next_st.ints       = INT_NONE;
      next_st.fetches    = FETCH_NORMAL;
      next_st.swap_write = 1'b0;
      next_st.cp_slow    = 1'b0;
      next_st.trap       = 1'b0;
      if (cond_pass_i) begin // RULE2
        case (cls)
          CLS_DATA_PROC: begin
            next_st.ints    = reg_shift_i ? INT_ONE : INT_NONE; // RULE3
            next_st.fetches = pc_written_i ? FETCH_BRANCH : FETCH_NORMAL; // RULE3
          end
          CLS_LOAD_SINGLE_WORD: begin
            next_st.reads   = (WORD_CNT_W+1)'(1); // RULE4
            next_st.ints    = INT_ONE;
            next_st.fetches = pc_written_i ? FETCH_BRANCH : FETCH_NORMAL;
          end
          CLS_STORE_SINGLE_WORD: next_st.writes = (WORD_CNT_W+1)'(1); // RULE5
          CLS_LOAD_MULTIPLE_WORDS: begin
            next_st.reads   = n_words; // RULE6
            next_st.ints    = INT_ONE;
            next_st.fetches = pc_written_i ? FETCH_BRANCH : FETCH_NORMAL;
          end
          CLS_STORE_MULTIPLE_WORDS: next_st.writes = n_words; // RULE7
          CLS_ATOMIC_SWAP: begin
            next_st.reads      = (WORD_CNT_W+1)'(1); // RULE8
            next_st.swap_write = 1'b1;
            next_st.ints       = INT_ONE;
          end
          CLS_BRANCH, CLS_SOFTWARE_INTERRUPT_OP: next_st.fetches = FETCH_BRANCH;
          CLS_MULTIPLY_OP: next_st.ints = mul_cycles(multiplier_operand_register_i);
          CLS_MOVE_TO_COPROCESSOR, CLS_MOVE_FROM_COPROCESSOR: begin
            if (cp_ok) begin
              next_st.ints    = INT_CP15; // RULE14
              next_st.cp_slow = 1'b1; // RULE19
            end else begin
              next_st.trap    = 1'b1; // RULE13
              next_st.fetches = FETCH_BRANCH;
            end
          end
          CLS_COPROCESSOR_DATA_OP, CLS_COPROCESSOR_LOAD, CLS_COPROCESSOR_STORE: begin
            next_st.trap    = 1'b1; // RULE12
            next_st.fetches = FETCH_BRANCH;
          end
          default: next_st.fetches = FETCH_NORMAL;
        endcase
      end
      next_st.total = 6'(next_st.reads) + 6'(next_st.writes) + 6'(next_st.ints)
                    + (next_st.swap_write ? 6'h01 : 6'h00) + 6'(next_st.fetches);
      // Fixed order: reads, writes, internal, then fetches
      if (next_st.reads != '0) begin
        next_st.phase = PH_READ;
      end else if (next_st.writes != '0 || next_st.swap_write) begin
        next_st.phase = PH_WRITE;
      end else if (next_st.ints != INT_NONE) begin
        next_st.phase = PH_INT;
      end else begin
        next_st.phase = PH_FETCH;
      end
    end else if (step) begin
      case (st.phase)
        PH_READ: begin
          next_st.reads = st.reads - (WORD_CNT_W+1)'(1);
          if (st.reads == (WORD_CNT_W+1)'(1)) begin
            next_st.phase = (st.writes != '0 || st.swap_write) ? PH_WRITE // RULE8
                          : (st.ints != INT_NONE) ? PH_INT : PH_FETCH;
          end
        end
        PH_WRITE: begin
          next_st.swap_write = 1'b0;
          if (!st.swap_write) begin
            next_st.writes = st.writes - (WORD_CNT_W+1)'(1);
          end
          if (st.swap_write || st.writes == (WORD_CNT_W+1)'(1)) begin
            next_st.phase = (st.ints != INT_NONE) ? PH_INT : PH_FETCH;
          end
        end
        PH_INT: begin
          next_st.ints = st.ints - 5'h01;
          if (st.ints == INT_ONE) begin
            next_st.phase = PH_FETCH;
          end
        end
        PH_FETCH: begin
          next_st.fetches = st.fetches - 2'h1;
          if (st.fetches == FETCH_NORMAL) begin
            next_st.phase = PH_IDLE;
          end
        end
        default: next_st.phase = PH_IDLE;
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '{phase: PH_IDLE, reads: '0, writes: '0, ints: INT_NONE, fetches: 2'h0,
              swap_write: 1'b0, cp_slow: 1'b0, trap: 1'b0, total: 6'h00};
    end else begin
      st <= next_st;
    end
  end

  // Decode and prefetch only move when the last fetch of execute retires
  assign instr_ready_o    = !busy; // RULE1 RULE20
  assign advance_o        = (st.phase == PH_FETCH) && step && (st.fetches == FETCH_NORMAL); // RULE20
  assign fetch_cycle_o    = (st.phase == PH_FETCH);
  assign read_cycle_o     = (st.phase == PH_READ);
  assign write_cycle_o    = (st.phase == PH_WRITE);
  assign internal_cycle_o = (st.phase == PH_INT);
  assign mem_request_o    = mem_phase;
  assign undef_trap_o     = busy && st.trap;
  assign cycle_total_o    = st.total;

  a_trap_class: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE12
    (!busy && instr_valid_i && cond_pass_i && (cls == CLS_COPROCESSOR_DATA_OP))
      |=> undef_trap_o)
    else $error("coprocessor data op did not trap");
  a_skip_cost: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
    (!busy && instr_valid_i && !cond_pass_i) |=> fetch_cycle_o && cycle_total_o == 6'h01)
    else $error("skipped instruction not single fetch");
  a_cp15_cost: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE14
    (!busy && instr_valid_i && cond_pass_i && cls == CLS_MOVE_TO_COPROCESSOR && cp_ok)
      |=> cycle_total_o == 6'h03)
    else $error("cp15 transfer cost wrong");
  a_mul_max: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE11
    (!busy && instr_valid_i && cond_pass_i && cls == CLS_MULTIPLY_OP
      && multiplier_operand_register_i[31:29] != 3'h0) |=> cycle_total_o == 6'h11)
    else $error("large multiplier cost wrong");
  a_mul_min: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE10
    (!busy && instr_valid_i && cond_pass_i && cls == CLS_MULTIPLY_OP
      && multiplier_operand_register_i[31:1] == 31'h0) |=> internal_cycle_o ##1 fetch_cycle_o)
    else $error("small multiply not 1S+1I");
  a_store_seq: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE5
    (!busy && instr_valid_i && cond_pass_i && cls == CLS_STORE_SINGLE_WORD)
      |=> write_cycle_o && cycle_total_o == 6'h02)
    else $error("store word sequence wrong");
  a_read_stall: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE16
    (read_cycle_o && !cache_hit_i && !mem_done_i) |=> $stable(st.reads) && read_cycle_o)
    else $error("read miss did not stall");
  a_write_stall: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE17
    (write_cycle_o && wbuf_enable_i && !wbuf_space_i) |=> write_cycle_o)
    else $error("full write buffer did not stall");
  a_hold_fetch: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE20
    (busy && mem_wait) |-> (!advance_o && !instr_ready_o) ##1 $stable(st.phase))
    else $error("pipeline advanced during stall");
  a_swap_order: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE8
    (read_cycle_o && st.swap_write && step) |=> write_cycle_o)
    else $error("swap write did not follow read");

endmodule

/* File: verification/memory_system_model.sv */
// Memory system model: cache, write buffer and external memory behind the sequencer
`timescale 1ns/100ps
module memory_system_model #(
  parameter int LAT = 3
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic miss_i,
  input  wire logic mem_request_i,
  input  wire logic write_cycle_i,
  input  wire logic wbuf_enable_i,
  output logic      cache_hit_o,
  output logic      mem_done_o,
  output logic      wbuf_space_o
);
  logic [7:0] wait_cnt;
  // Slow path: a miss, or a write with the buffer off, costs LAT extra cycles
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      wait_cnt <= 8'h00;
    else if (mem_request_i && (miss_i || (write_cycle_i && !wbuf_enable_i)) &&
             wait_cnt != 8'(LAT))
      wait_cnt <= wait_cnt + 8'h01;
    else
      wait_cnt <= 8'h00;
  end
  // Done is a one-cycle pulse; buffer room frees only when the slow access ends
  assign cache_hit_o  = !miss_i;
  assign mem_done_o   = (wait_cnt == 8'(LAT));
  assign wbuf_space_o = !miss_i || mem_done_o;
endmodule

/* File: verification/instruction_cycle_timing_test.sv */
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/100ps
module instruction_cycle_timing_test
  import cycle_timing_pkg::*;
;
  localparam int LAT = 3;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        valid = 1'b0, cond = 1'b1, rsh = 1'b0, pcw = 1'b0, cp_en = 1'b0;
  logic        wben = 1'b1, miss = 1'b0, hit, done, space;
  logic [3:0]  cls = 4'h0, cpn = 4'h0, cpr = 4'h0;
  logic [4:0]  wcnt = 5'h01;
  logic [31:0] mval = 32'h0;
  logic        ready, adv, f_o, r_o, w_o, i_o, req, trap;
  logic [5:0]  total;
  int          errors = 0;
  int          cmp_count = 0;

  instruction_cycle_timing #(.WORD_CNT_W(5)) instruction_cycle_timing_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(valid), .instr_class_i(cls),
    .cond_pass_i(cond), .reg_shift_i(rsh), .pc_written_i(pcw), .word_count_i(wcnt),
    .multiplier_operand_register_i(mval), .cp_num_i(cpn), .cp_reg_i(cpr),
    .coprocessor_clock_en_i(cp_en), .cache_hit_i(hit), .mem_done_i(done),
    .wbuf_enable_i(wben), .wbuf_space_i(space), .instr_ready_o(ready), .advance_o(adv),
    .fetch_cycle_o(f_o), .read_cycle_o(r_o), .write_cycle_o(w_o), .internal_cycle_o(i_o),
    .mem_request_o(req), .undef_trap_o(trap), .cycle_total_o(total));
  memory_system_model #(.LAT(LAT)) memory_system_model_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .miss_i(miss), .mem_request_i(req),
    .write_cycle_i(w_o), .wbuf_enable_i(wben), .cache_hit_o(hit), .mem_done_o(done),
    .wbuf_space_o(space));

  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Coprocessor clock enable, one core cycle in two
  always @(negedge clk_i) cp_en <= ~cp_en;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Sample 1 ns past the falling edge so the enable toggle has landed
  task automatic tick();
    @(negedge clk_i);
    #1;
  endtask

  // One instruction: offer it, then tally completed steps until it retires
  task automatic run(input logic [3:0] c, input logic cd, rs, pc, input logic [4:0] n,
                     input logic [31:0] mv, input logic [3:0] cn, cr,
                     input int ef, er, ew, ei, input logic et);
    int   f, r, w, i, t, rk, ph;
    logic tr, cq, st;
    f = 0; r = 0; w = 0; i = 0; t = 0; rk = 0; tr = 1'b0;
    cq = (c == CLS_MOVE_TO_COPROCESSOR || c == CLS_MOVE_FROM_COPROCESSOR) && cd &&
         cn == CP_SYSCTRL && cr <= CP_REG_LIMIT;
    tick();
    cls = c; cond = cd; rsh = rs; pcw = pc; wcnt = n; mval = mv; cpn = cn; cpr = cr;
    valid = 1'b1;
    chk(ready, 1);
    tick();
    valid = 1'b0;
    chk(total, ef + er + ew + ei);
    forever begin
      st = (f_o | r_o) ? (hit | done) : w_o ? (wben ? space : done) : (i_o & (cp_en | !cq));
      ph = f_o ? 3 : i_o ? 2 : w_o ? 1 : 0;
      chk(ph >= rk, 1);
      chk(ready | adv & !f_o, 0);
      chk(req, f_o | r_o | w_o);
      rk = ph;
      f += int'(f_o & st);
      r += int'(r_o & st);
      w += int'(w_o & st);
      i += int'(i_o & st);
      tr |= trap;
      t++;
      if (adv === 1'b1 || t > 400) break;
      tick();
    end
    chk(t <= 400, 1);
    chk(f, ef);
    chk(r, er);
    chk(w, ew);
    chk(i, ei);
    chk(tr, et);
    if (!cq)
      chk(t, (ef + er) * (miss ? LAT + 1 : 1) + ew * ((miss || !wben) ? LAT + 1 : 1) + ei);
  endtask

  task automatic t_data();
    run(CLS_DATA_PROC, 1, 0, 0, 1, 0, 0, 0, 1, 0, 0, 0, 0);
    run(CLS_DATA_PROC, 1, 1, 0, 1, 0, 0, 0, 1, 0, 0, 1, 0);
    run(CLS_DATA_PROC, 1, 0, 1, 1, 0, 0, 0, 3, 0, 0, 0, 0);
    run(CLS_DATA_PROC, 1, 1, 1, 1, 0, 0, 0, 3, 0, 0, 1, 0);
    run(CLS_PSR_MOVE, 1, 0, 0, 1, 0, 0, 0, 1, 0, 0, 0, 0);
    run(CLS_BRANCH, 1, 0, 0, 1, 0, 0, 0, 3, 0, 0, 0, 0);
    run(CLS_SOFTWARE_INTERRUPT_OP, 1, 0, 0, 1, 0, 0, 0, 3, 0, 0, 0, 0);
    run(CLS_LOAD_MULTIPLE_WORDS, 0, 0, 1, 9, 0, 0, 0, 1, 0, 0, 0, 0);
    run(CLS_COPROCESSOR_LOAD, 0, 0, 0, 1, 0, 0, 0, 1, 0, 0, 0, 0);
  endtask

  task automatic t_mem();
    run(CLS_LOAD_SINGLE_WORD, 1, 0, 0, 1, 0, 0, 0, 1, 1, 0, 1, 0);
    run(CLS_LOAD_SINGLE_WORD, 1, 0, 1, 1, 0, 0, 0, 3, 1, 0, 1, 0);
    run(CLS_STORE_SINGLE_WORD, 1, 0, 0, 1, 0, 0, 0, 1, 0, 1, 0, 0);
    run(CLS_LOAD_MULTIPLE_WORDS, 1, 0, 0, 1, 0, 0, 0, 1, 1, 0, 1, 0);
    run(CLS_LOAD_MULTIPLE_WORDS, 1, 0, 1, 31, 0, 0, 0, 3, 31, 0, 1, 0);
    run(CLS_STORE_MULTIPLE_WORDS, 1, 0, 0, 31, 0, 0, 0, 1, 0, 31, 0, 0);
    run(CLS_STORE_MULTIPLE_WORDS, 1, 0, 0, 1, 0, 0, 0, 1, 0, 1, 0, 0);
    run(CLS_ATOMIC_SWAP, 1, 0, 0, 1, 0, 0, 0, 1, 1, 1, 1, 0);
  endtask

  // Multiplier boundaries and the cycle count each must give
  task automatic t_mul();
    logic [31:0] v[8] = '{32'h0, 32'h1, 32'h2, 32'h7, 32'h8, 32'h1FFFFFFF, 32'h20000000,
                          32'hFFFFFFFF};
    int          m[8] = '{1, 1, 2, 2, 3, 15, 16, 16};
    for (int k = 0; k < 8; k++) begin
      run(CLS_MULTIPLY_OP, 1, 0, 0, 1, v[k], 0, 0, 1, 0, 0, m[k], 0);
    end
  endtask

  task automatic t_cop();
    run(CLS_COPROCESSOR_DATA_OP, 1, 0, 0, 1, 0, 4'hF, 0, 3, 0, 0, 0, 1);
    run(CLS_COPROCESSOR_LOAD, 1, 0, 0, 1, 0, 4'hF, 0, 3, 0, 0, 0, 1);
    run(CLS_COPROCESSOR_STORE, 1, 0, 0, 1, 0, 4'hF, 0, 3, 0, 0, 0, 1);
    run(CLS_MOVE_TO_COPROCESSOR, 1, 0, 0, 1, 0, 4'hF, 4'h0, 1, 0, 0, 2, 0);
    run(CLS_MOVE_FROM_COPROCESSOR, 1, 0, 0, 1, 0, 4'hF, 4'h7, 1, 0, 0, 2, 0);
    run(CLS_MOVE_FROM_COPROCESSOR, 1, 0, 0, 1, 0, 4'hF, 4'h8, 3, 0, 0, 0, 1);
    run(CLS_MOVE_TO_COPROCESSOR, 1, 0, 0, 1, 0, 4'hE, 4'h0, 3, 0, 0, 0, 1);
  endtask

  // Misses and a full or disabled write buffer stretch memory steps only
  task automatic t_stall();
    // Let the last fetch retire before misses start, or it would stall
    tick();
    miss = 1'b1;
    run(CLS_ATOMIC_SWAP, 1, 0, 0, 1, 0, 0, 0, 1, 1, 1, 1, 0);
    run(CLS_LOAD_MULTIPLE_WORDS, 1, 0, 1, 2, 0, 0, 0, 3, 2, 0, 1, 0);
    miss = 1'b0;
    wben = 1'b0;
    run(CLS_STORE_MULTIPLE_WORDS, 1, 0, 0, 3, 0, 0, 0, 1, 0, 3, 0, 0);
    wben = 1'b1;
  endtask

  task automatic stop_test();
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_data();
    t_mem();
    t_mul();
    t_cop();
    t_stall();
    stop_test();
  end
  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule
